/* File: i2cs_pkg.sv */
// shared constants for the two-wire status and address-mask block
package i2cs_pkg;
  // register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // register indices
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK = 4'h1;
  localparam logic [3:0] REG_CTRL = 4'h2;
  localparam logic [3:0] REG_TXBUF = 4'h3;
  localparam logic [3:0] REG_RXBUF = 4'h4;
  localparam logic [3:0] REG_INT_STAT = 4'h5;
  localparam logic [3:0] REG_INT_MASK = 4'h6;
  localparam logic [3:0] REG_OWN_ADDR = 4'h7;
  // bus_status_flags field positions
  localparam int ST_ACK_RESULT = 15;
  localparam int ST_MTX_BUSY = 14;
  localparam int ST_ACK_WINDOW = 13;
  localparam int ST_BUS_COLL = 10;
  localparam int ST_GEN_CALL = 9;
  localparam int ST_TEN_BIT = 8;
  localparam int ST_WR_COLL = 7;
  localparam int ST_RX_OVF = 6;
  localparam int ST_DATA_ADDR = 5;
  localparam int ST_STOP = 4;
  localparam int ST_START = 3;
  localparam int ST_READ_WRITE = 2;
  localparam int ST_RX_FULL = 1;
  localparam int ST_TX_FULL = 0;
  // control register fields
  localparam int CTRL_TEN_BIT = 10;
  localparam int CTRL_GC_EN = 7;
  // interrupt event positions
  localparam int EV_START = 0;
  localparam int EV_STOP = 1;
  localparam int EV_ADDR_HIT = 2;
  localparam int EV_RX_BYTE = 3;
  localparam int EV_BUS_COLL = 4;
  localparam int EV_WR_COLL = 5;
  localparam int EV_RX_OVF = 6;
  localparam int EV_MACK_END = 7;
  localparam int EV_W = 8;
  // reset values and implemented-bit masks
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [9:0] OWN_ADDR_RST = 10'h000;
  localparam logic [15:0] MASK_IMPL = 16'h03FF;
  localparam logic [15:0] CTRL_IMPL = 16'h0480;
  // protocol constants
  localparam logic [7:0] GEN_CALL_BYTE = 8'h00;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage

/* File: i2cs_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module i2cs_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pins in, synchronised copy out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] stage1;

  // idle bus level is high, so both stages reset high
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= '1;
      pin_sync <= '1;
    end
    else
    begin
      stage1 <= pin_in;
      pin_sync <= stage1;
    end
  end
endmodule
`default_nettype wire

/* File: i2cs_addr_match.sv */
// masked comparison of a received address byte against the own address
`timescale 1ns/1ps
`default_nettype none
module i2cs_addr_match (
  // configuration
  input wire logic ten_bit_address_select,
  input wire logic gc_enable,
  input wire logic [9:0] own_slave_address,
  input wire logic [9:0] address_mask_bits,
  // byte under test
  input wire logic [7:0] rx_byte,
  // results
  output logic hit_7,
  output logic hit_10_hi,
  output logic hit_10_lo,
  output logic hit_gc
);
  // a set mask bit removes that position from the compare
  function automatic logic masked_eq(input logic [9:0] a, input logic [9:0] b,
                                     input logic [9:0] m);
    masked_eq = ((a ^ b) & ~m) == 10'h000;
  endfunction

  // 7-bit: mask bit n covers byte bit n+1, only mask bits 6:0 used
  assign hit_7 = !ten_bit_address_select &&
    masked_eq({3'h0, rx_byte[7:1]}, {3'h0, own_slave_address[6:0]},
              {3'h0, address_mask_bits[6:0]});
  // 10-bit: mask bit x covers address bit x
  assign hit_10_hi = ten_bit_address_select &&
    (rx_byte[7:3] == i2cs_pkg::TEN_BIT_PREFIX) &&
    masked_eq({8'h00, rx_byte[2:1]}, {8'h00, own_slave_address[9:8]},
              {8'h00, address_mask_bits[9:8]});
  assign hit_10_lo = ten_bit_address_select &&
    masked_eq({2'h0, rx_byte}, {2'h0, own_slave_address[7:0]},
              {2'h0, address_mask_bits[7:0]});
  assign hit_gc = gc_enable && (rx_byte == i2cs_pkg::GEN_CALL_BYTE);
endmodule
`default_nettype wire

/* File: i2cs_status.sv */
// status flags, address mask and slave bus monitor of the two-wire controller
// ==========================================================================
// ==========================================================================
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module i2cs_status (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // bus pins, sampled only
  input wire logic serial_clock_line,
  input wire logic serial_data_line,
  // master engine events, same clock
  input wire logic master_active,
  input wire logic master_tx_begin,
  input wire logic master_ack_end,
  input wire logic master_ack_nack,
  input wire logic bus_collision_det,
  // transmit shifter
  input wire logic tx_done,
  output logic [7:0] transmit_buffer,
  output logic tx_full,
  // slave state and interrupt
  output logic slave_addressed,
  output logic irq
);
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_ADDR2 = 2'b10,
    PH_DATA = 2'b11
  } i2cs_phase_t;

  logic rst_meta, rst_n;
  logic scl_s, sda_s, scl_q, sda_q;
  logic scl_rise, scl_fall, start_det, stop_det, byte_done, in_frame, ack_phase;
  logic [3:0] bit_cnt;
  logic [7:0] receive_shift_register, receive_buffer;
  i2cs_phase_t phase;
  logic [15:0] slave_address_mask, ctrl;
  logic [9:0] own_slave_address;
  logic slave_ack_result, master_tx_in_progress, ack_window_flag, bus_collision_flag;
  logic general_call_seen, ten_bit_matched, tx_write_collision, rx_overflow_flag;
  logic data_not_address, stop_seen, start_seen, read_not_write;
  logic rx_buffer_full, tx_buffer_full;
  logic hit_7, hit_10_hi, hit_10_lo, hit_gc, addr_hit, rx_store, tx_busy;
  logic wr_status, wr_txbuf, rd_rxbuf;
  logic [15:0] bus_status_flags;
  logic [i2cs_pkg::EV_W-1:0] int_stat, int_mask, events;

  // ========================================================================
  // reset release
  // ========================================================================
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ========================================================================
  // pin sampling and bus conditions
  // ========================================================================
  i2cs_sync #(.WIDTH(2)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in({serial_clock_line, serial_data_line}),
    .pin_sync({scl_s, sda_s})
  );

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;
  assign start_det = scl_s && scl_q && sda_q && !sda_s;
  assign stop_det = scl_s && scl_q && !sda_q && sda_s;
  // the 8th falling edge closes a byte; ack_phase stops a second hit
  assign byte_done = in_frame && scl_fall && (bit_cnt == i2cs_pkg::BITS_PER_BYTE) && !ack_phase;

  // bit counter and shifter; a start restarts the count mid-byte
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_frame <= 1'b0;
      bit_cnt <= 4'h0;
      ack_phase <= 1'b0;
      receive_shift_register <= 8'h00;
    end
    else if (start_det || stop_det)
    begin
      in_frame <= start_det;
      bit_cnt <= 4'h0;
      ack_phase <= 1'b0;
    end
    else if (in_frame && scl_rise)
    begin
      if (bit_cnt == i2cs_pkg::BITS_PER_BYTE)
      begin
        bit_cnt <= 4'h0;
        ack_phase <= 1'b0;
      end
      else
      begin
        bit_cnt <= bit_cnt + 4'h1;
        receive_shift_register <= {receive_shift_register[6:0], sda_s};
      end
    end
    else if (byte_done)
      ack_phase <= 1'b1;
  end

  // ========================================================================
  // address matching and slave phase
  // ========================================================================
  i2cs_addr_match u_match (
    .ten_bit_address_select(ctrl[i2cs_pkg::CTRL_TEN_BIT]),
    .gc_enable(ctrl[i2cs_pkg::CTRL_GC_EN]),
    .own_slave_address(own_slave_address),
    .address_mask_bits(slave_address_mask[9:0]),
    .rx_byte(receive_shift_register),
    .hit_7(hit_7),
    .hit_10_hi(hit_10_hi),
    .hit_10_lo(hit_10_lo),
    .hit_gc(hit_gc)
  );

  // a ten-bit read after a restart needs only the first byte to match
  always_comb
  begin
    addr_hit = 1'b0;
    if (byte_done && !master_active)
    begin
      unique case (phase)
        PH_ADDR: addr_hit = hit_7 || hit_gc ||
          (hit_10_hi && receive_shift_register[0] && ten_bit_matched);
        PH_ADDR2: addr_hit = hit_10_lo;
        default: addr_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      phase <= PH_IDLE;
    else if (stop_det)
      phase <= PH_IDLE;
    else if (start_det)
      phase <= PH_ADDR;
    else if (byte_done && !master_active)
    begin
      unique case (phase)
        PH_IDLE: phase <= PH_IDLE;
        PH_ADDR: phase <= addr_hit ? PH_DATA :
          (hit_10_hi && !receive_shift_register[0]) ? PH_ADDR2 : PH_IDLE;
        PH_ADDR2: phase <= hit_10_lo ? PH_DATA : PH_IDLE;
        PH_DATA: phase <= PH_DATA;
      endcase
    end
  end

  assign slave_addressed = (phase == PH_DATA);
  assign rx_store = byte_done && !master_active && slave_addressed && !read_not_write;

  // ========================================================================
  // register strobes and writable registers
  // ========================================================================
  assign wr_status = reg_wr && (reg_addr == i2cs_pkg::REG_STATUS);
  assign wr_txbuf = reg_wr && (reg_addr == i2cs_pkg::REG_TXBUF);
  assign rd_rxbuf = reg_rd && (reg_addr == i2cs_pkg::REG_RXBUF);
  assign tx_busy = tx_buffer_full || master_tx_in_progress;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slave_address_mask <= i2cs_pkg::MASK_RST;
      ctrl <= i2cs_pkg::CTRL_RST;
      own_slave_address <= i2cs_pkg::OWN_ADDR_RST;
      int_mask <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == i2cs_pkg::REG_MASK)
        slave_address_mask <= reg_wdata & i2cs_pkg::MASK_IMPL;
      if (reg_addr == i2cs_pkg::REG_CTRL)
        ctrl <= reg_wdata & i2cs_pkg::CTRL_IMPL;
      if (reg_addr == i2cs_pkg::REG_OWN_ADDR)
        own_slave_address <= reg_wdata[9:0];
      if (reg_addr == i2cs_pkg::REG_INT_MASK)
        int_mask <= reg_wdata[i2cs_pkg::EV_W-1:0];
    end
  end

  // transmit buffer: a write while busy never lands
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      transmit_buffer <= 8'h00;
      tx_buffer_full <= 1'b0;
    end
    else if (wr_txbuf && !tx_busy)
    begin
      transmit_buffer <= reg_wdata[7:0];
      tx_buffer_full <= 1'b1;
    end
    else if (tx_done)
      tx_buffer_full <= 1'b0;
  end
  assign tx_full = tx_buffer_full;

  // receive buffer: a full buffer is kept, the new byte is lost
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      receive_buffer <= 8'h00;
      rx_buffer_full <= 1'b0;
    end
    else if (rx_store && !rx_buffer_full)
    begin
      receive_buffer <= receive_shift_register;
      rx_buffer_full <= 1'b1;
    end
    else if (rd_rxbuf)
      rx_buffer_full <= 1'b0;
  end

  // ========================================================================
  // status flags; hardware set wins over a software clear in the same cycle
  // ========================================================================
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slave_ack_result <= 1'b0;
      master_tx_in_progress <= 1'b0;
    end
    else
    begin
      if (master_ack_end)
        slave_ack_result <= master_ack_nack;
      if (master_ack_end)
        master_tx_in_progress <= 1'b0;
      else if (master_tx_begin)
        master_tx_in_progress <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ack_window_flag <= 1'b0;
    else if (byte_done && !master_active)
      ack_window_flag <= 1'b1;
    else if ((in_frame && scl_rise && bit_cnt == i2cs_pkg::BITS_PER_BYTE) || start_det || stop_det)
      ack_window_flag <= 1'b0;
  end

  // software-clearable flags: written 0 clears, written 1 is ignored
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_collision_flag <= 1'b0;
      tx_write_collision <= 1'b0;
      rx_overflow_flag <= 1'b0;
    end
    else
    begin
      if (bus_collision_det)
        bus_collision_flag <= 1'b1;
      else if (wr_status && !reg_wdata[i2cs_pkg::ST_BUS_COLL])
        bus_collision_flag <= 1'b0;
      if (wr_txbuf && tx_busy)
        tx_write_collision <= 1'b1;
      else if (wr_status && !reg_wdata[i2cs_pkg::ST_WR_COLL])
        tx_write_collision <= 1'b0;
      if (rx_store && rx_buffer_full)
        rx_overflow_flag <= 1'b1;
      else if (wr_status && !reg_wdata[i2cs_pkg::ST_RX_OVF])
        rx_overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end
    else if (start_det)
    begin
      start_seen <= 1'b1;
      stop_seen <= 1'b0;
    end
    else if (stop_det)
    begin
      start_seen <= 1'b0;
      stop_seen <= 1'b1;
    end
    else if (wr_status)
    begin
      start_seen <= start_seen && reg_wdata[i2cs_pkg::ST_START];
      stop_seen <= stop_seen && reg_wdata[i2cs_pkg::ST_STOP];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      general_call_seen <= 1'b0;
      ten_bit_matched <= 1'b0;
      data_not_address <= 1'b0;
      read_not_write <= 1'b0;
    end
    else if (stop_det)
    begin
      general_call_seen <= 1'b0;
      ten_bit_matched <= 1'b0;
    end
    else if (addr_hit)
    begin
      data_not_address <= 1'b0;
      if (phase == PH_ADDR2)
        ten_bit_matched <= 1'b1;
      // a second ten-bit byte only follows a first byte that asked for a write
      read_not_write <= (phase != PH_ADDR2) && receive_shift_register[0];
      if (phase == PH_ADDR && hit_gc)
        general_call_seen <= 1'b1;
    end
    else if (byte_done && slave_addressed && !master_active)
      data_not_address <= 1'b1;
  end

  assign bus_status_flags = {slave_ack_result, master_tx_in_progress, ack_window_flag,
    2'b00, bus_collision_flag, general_call_seen, ten_bit_matched, tx_write_collision,
    rx_overflow_flag, data_not_address, stop_seen, start_seen, read_not_write,
    rx_buffer_full, tx_buffer_full};

  // ========================================================================
  // interrupt: sticky events, write one to clear, set wins
  // ========================================================================
  always_comb
  begin
    events = '0;
    events[i2cs_pkg::EV_START] = start_det;
    events[i2cs_pkg::EV_STOP] = stop_det;
    events[i2cs_pkg::EV_ADDR_HIT] = addr_hit;
    events[i2cs_pkg::EV_RX_BYTE] = rx_store && !rx_buffer_full;
    events[i2cs_pkg::EV_BUS_COLL] = bus_collision_det;
    events[i2cs_pkg::EV_WR_COLL] = wr_txbuf && tx_busy;
    events[i2cs_pkg::EV_RX_OVF] = rx_store && rx_buffer_full;
    events[i2cs_pkg::EV_MACK_END] = master_ack_end;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      int_stat <= '0;
    else if (reg_wr && reg_addr == i2cs_pkg::REG_INT_STAT)
      int_stat <= (int_stat & ~reg_wdata[i2cs_pkg::EV_W-1:0]) | events;
    else
      int_stat <= int_stat | events;
  end
  assign irq = |(int_stat & int_mask);

  // ========================================================================
  // read data, valid the cycle after the strobe; unmapped reads as zero
  // ========================================================================
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        i2cs_pkg::REG_STATUS: reg_rdata <= bus_status_flags;
        i2cs_pkg::REG_MASK: reg_rdata <= slave_address_mask;
        i2cs_pkg::REG_CTRL: reg_rdata <= ctrl;
        i2cs_pkg::REG_TXBUF: reg_rdata <= {8'h00, transmit_buffer};
        i2cs_pkg::REG_RXBUF: reg_rdata <= {8'h00, receive_buffer};
        i2cs_pkg::REG_INT_STAT: reg_rdata <= {8'h00, int_stat};
        i2cs_pkg::REG_INT_MASK: reg_rdata <= {8'h00, int_mask};
        i2cs_pkg::REG_OWN_ADDR: reg_rdata <= {6'h00, own_slave_address};
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

  // ========================================================================
  // assertions
  // ========================================================================
  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_ack_result_nack: assert property (master_ack_end |=> slave_ack_result == $past(master_ack_nack)) else $error("ack result wrong");
  a_mtx_busy_span: assert property (master_tx_begin && !master_ack_end ##1 !master_ack_end[*2] |-> master_tx_in_progress) else $error("transmit busy dropped");
  a_mtx_busy_clear: assert property (master_ack_end |=> !master_tx_in_progress) else $error("transmit busy not cleared");
  a_ack_window_set: assert property (byte_done && !master_active |=> ack_window_flag) else $error("ack window not set");
  a_collision_sticky: assert property (bus_collision_flag && !wr_status |=> bus_collision_flag) else $error("collision flag lost");
  a_stop_clears_match: assert property (stop_det |=> !general_call_seen && !ten_bit_matched && stop_seen && !start_seen) else $error("stop flags wrong");
  a_tx_write_reject: assert property (wr_txbuf && tx_busy |=> tx_write_collision && $stable(transmit_buffer)) else $error("busy write accepted");
  a_rx_overflow_keep: assert property (rx_store && rx_buffer_full |=> rx_overflow_flag && $stable(receive_buffer)) else $error("overflow not flagged");
  a_start_flags: assert property (start_det |=> start_seen && !stop_seen) else $error("start flags wrong");
  a_rx_full_read: assert property (rd_rxbuf && !rx_store |=> !rx_buffer_full) else $error("receive full not cleared");
  a_status_reserved_zero: assert property ($past(reg_rd) && $past(reg_addr) == i2cs_pkg::REG_STATUS |-> reg_rdata[12:11] == 2'b00) else $error("reserved bits set");

  c_start_stop: cover property (start_det ##[1:1000] stop_det);
  c_addr_hit: cover property (addr_hit);
  c_rx_overflow: cover property (rx_store && rx_buffer_full);
  c_write_collision: cover property (wr_txbuf && tx_busy);
endmodule
`default_nettype wire

/* File: i2cs_remote.sv */
// remote bus master model that drives the two bus lines
`timescale 1ns/1ps
`default_nettype none
module i2cs_remote (
  // bus lines, pulled up when released
  output logic serial_clock_line,
  output logic serial_data_line
);
  // clock stands high between frames; a released data line shows the pull-up
  initial
  begin
    serial_clock_line = 1'b1;
    serial_data_line = 1'b1;
  end
  // one 320 ns bit cell, data changes only while the clock is low
  task automatic bit_cell(input logic v);
  begin
    serial_data_line = v;
    #80;
    serial_clock_line = 1'b1;
    #160;
    serial_clock_line = 1'b0;
    #80;
  end
  endtask
  // works from idle and as a repeated start in mid-frame
  task automatic start_cond();
  begin
    serial_data_line = 1'b1;
    #80;
    serial_clock_line = 1'b1;
    #80;
    serial_data_line = 1'b0;
    #80;
    serial_clock_line = 1'b0;
    #80;
  end
  endtask
  // eight bits msb first, then an ack cell with the line released
  task automatic send_byte(input logic [7:0] b);
  begin
    for (int i = 7; i >= 0; i--)
      bit_cell(b[i]);
    bit_cell(1'b1);
  end
  endtask
  task automatic stop_cond();
  begin
    serial_data_line = 1'b0;
    #80;
    serial_clock_line = 1'b1;
    #80;
    serial_data_line = 1'b1;
    #160;
  end
  endtask
endmodule
`default_nettype wire

/* File: tb_i2cs_status.sv */
// self-checking bench for the status and address-mask block
`timescale 1ns/1ps
`default_nettype none
module tb_i2cs_status;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  // tx done, collision, nack, ack end, tx begin
  logic [4:0] ev = 5'h00;
  logic scl;
  logic sda;
  logic [7:0] txb;
  logic txf;
  logic irq;
  logic sla;
  logic mact = 1'b0;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  always #20 clk_sys = ~clk_sys;
  i2cs_remote rem (.serial_clock_line(scl), .serial_data_line(sda));
  i2cs_status uut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_clock_line(scl), .serial_data_line(sda), .master_active(mact),
    .master_tx_begin(ev[0]), .master_ack_end(ev[1]), .master_ack_nack(ev[2]),
    .bus_collision_det(ev[3]), .tx_done(ev[4]), .transmit_buffer(txb), .tx_full(txf),
    .slave_addressed(sla), .irq(irq));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
  begin
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
  begin
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  end
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
  begin
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata & m, exp);
  end
  endtask
  task automatic pulse(input logic [4:0] v);
  begin
    @(posedge clk_sys);
    ev <= v;
    @(posedge clk_sys);
    ev <= 5'h00;
    repeat (2) @(posedge clk_sys);
  end
  endtask
  // leave time for the pin synchroniser and edge detect
  task automatic tx(input logic [7:0] b);
  begin
    rem.send_byte(b);
    repeat (4) @(posedge clk_sys);
  end
  endtask
  task automatic wrap_up();
  begin
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(i2cs_pkg::REG_STATUS, 16'hFFFF, 16'h0000);
    wr(i2cs_pkg::REG_MASK, 16'hFFFF);
    rd(i2cs_pkg::REG_MASK, 16'hFFFF, 16'h03FF);
    $display("test registers done");
    // address 2A with byte bit 1 masked, write direction
    wr(i2cs_pkg::REG_MASK, 16'h0001);
    wr(i2cs_pkg::REG_OWN_ADDR, 16'h002A);
    wr(i2cs_pkg::REG_INT_MASK, 16'h0010);
    rem.start_cond();
    tx(8'h56);
    rd(i2cs_pkg::REG_STATUS, 16'hFFFF, 16'h0008);
    tx(8'h5A);
    rd(i2cs_pkg::REG_STATUS, 16'hFFFF, 16'h002A);
    tx(8'hC3);
    rd(i2cs_pkg::REG_STATUS, 16'hFFFF, 16'h006A);
    rd(i2cs_pkg::REG_RXBUF, 16'h00FF, 16'h005A);
    rd(i2cs_pkg::REG_STATUS, 16'h0002, 16'h0000);
    rem.start_cond();
    tx(8'h55);
    rd(i2cs_pkg::REG_STATUS, 16'h003C, 16'h000C);
    rem.stop_cond();
    repeat (4) @(posedge clk_sys);
    rd(i2cs_pkg::REG_STATUS, 16'h0018, 16'h0010);
    wr(i2cs_pkg::REG_STATUS, 16'hFFBF);
    rd(i2cs_pkg::REG_STATUS, 16'h0050, 16'h0010);
    $display("test seven-bit link done");
    // ten-bit own address 2A5, A0 masked
    wr(i2cs_pkg::REG_CTRL, 16'h0400);
    wr(i2cs_pkg::REG_OWN_ADDR, 16'h02A5);
    rem.start_cond();
    tx(8'hF4);
    tx(8'hA4);
    rd(i2cs_pkg::REG_STATUS, 16'h0104, 16'h0100);
    rem.stop_cond();
    repeat (4) @(posedge clk_sys);
    rd(i2cs_pkg::REG_STATUS, 16'h0100, 16'h0000);
    $display("test ten-bit link done");
    // general call, then a byte to be ignored while the master engine owns the bus
    wr(i2cs_pkg::REG_CTRL, 16'h0080);
    rem.start_cond();
    tx(8'h00);
    rd(i2cs_pkg::REG_STATUS, 16'h0224, 16'h0200);
    check({15'h0000, sla}, 16'h0001);
    mact <= 1'b1;
    tx(8'h5A);
    rd(i2cs_pkg::REG_STATUS, 16'h2022, 16'h0000);
    mact <= 1'b0;
    rem.stop_cond();
    repeat (4) @(posedge clk_sys);
    rd(i2cs_pkg::REG_STATUS, 16'h0200, 16'h0000);
    check({15'h0000, sla}, 16'h0000);
    $display("test general call done");
    pulse(5'h01);
    rd(i2cs_pkg::REG_STATUS, 16'h4000, 16'h4000);
    pulse(5'h06);
    rd(i2cs_pkg::REG_STATUS, 16'hC000, 16'h8000);
    wr(i2cs_pkg::REG_TXBUF, 16'h00A5);
    rd(i2cs_pkg::REG_STATUS, 16'h0081, 16'h0001);
    wr(i2cs_pkg::REG_TXBUF, 16'h003C);
    rd(i2cs_pkg::REG_STATUS, 16'h0080, 16'h0080);
    check({8'h00, txb}, 16'h00A5);
    pulse(5'h10);
    check({15'h0000, txf}, 16'h0000);
    pulse(5'h08);
    rd(i2cs_pkg::REG_STATUS, 16'h0400, 16'h0400);
    check({15'h0000, irq}, 16'h0001);
    wr(i2cs_pkg::REG_STATUS, 16'h0000);
    rd(i2cs_pkg::REG_STATUS, 16'h0480, 16'h0000);
    wr(i2cs_pkg::REG_INT_STAT, 16'h00FF);
    @(posedge clk_sys);
    #1;
    check({15'h0000, irq}, 16'h0000);
    $display("test master events done");
    wrap_up();
  end
endmodule
`default_nettype wire
